// [shared/sacc_pkg.sv]
// constants shared by the converter conversion control block
// assumes a single 125 MHz clock domain and an axi4-lite register port
package sacc_pkg;
   localparam int          SACC_NCHAN        = 4;
   localparam int          SACC_CONV_CYCLES  = 16;
   localparam int          SACC_INT_DIV      = 4;
   localparam int          SACC_DATA_W       = 14;
   // register byte offsets
   localparam logic [7:0]  SACC_OFS_CTRL     = 8'h00;
   localparam logic [7:0]  SACC_OFS_STATUS   = 8'h04;
   localparam logic [7:0]  SACC_OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0]  SACC_OFS_IRQ_MASK = 8'h0c;
   localparam logic [7:0]  SACC_OFS_RES0     = 8'h10;
   localparam logic [1:0]  SACC_RESP_OKAY    = 2'b00;
   localparam logic [1:0]  SACC_RESP_SLVERR  = 2'b10;
   localparam logic [31:0] SACC_CTRL_RST     = 32'h0000_0000;
   localparam logic [1:0]  SACC_IRQ_RST      = 2'b00;
   localparam int          SACC_IRQ_DONE     = 0;
   localparam int          SACC_IRQ_CHAN     = 1;
   typedef enum logic [1:0] {
      SACC_IDLE = 2'b00,
      SACC_CONV = 2'b01,
      SACC_NEXT = 2'b10
   } sacc_state_e;
endpackage

// [src/sacc_top.sv]
// conversion control: trigger, channel sequencing, parallel result port, axi4-lite mirror
// assumes the trigger, select, strobe and nibble pins asynchronous to aclk; results come from an analog core on conv_result
`timescale 1ns/1ps
module sacc_top #(
   parameter int NCHAN = sacc_pkg::SACC_NCHAN,
   parameter int DW    = sacc_pkg::SACC_DATA_W
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          sample_trigger,
   input  wire logic          ext_clock_or_chan_one_select,
   input  wire logic          clock_source_or_chan_two_select,
   input  wire logic [1:0]    chan_hi_select,
   input  wire logic          sw_control,
   input  wire logic          dev_select_n,
   input  wire logic          read_n,
   input  wire logic          write_n,
   input  wire logic [3:0]    low_data_nibble,
   input  wire logic [DW-1:0] conv_result,
   output logic [DW-1:0]      data_out,
   output logic               data_oe,
   output logic               busy,
   output logic               first_result_flag,
   output logic [3:0]         track_hold,
   output logic               irq,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready
);
   import sacc_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   localparam int NS = 13;
   // strobes rest high, so reset shows an idle bus and no phantom read
   localparam logic [NS-1:0] PIN_IDLE = 13'h0070;
   logic [NS-1:0] s1_q;
   logic [NS-1:0] s2_q;
   wire  [NS-1:0] pins = {sample_trigger, ext_clock_or_chan_one_select,
                          clock_source_or_chan_two_select, chan_hi_select,
                          sw_control, dev_select_n, read_n, write_n, low_data_nibble};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= PIN_IDLE;
         s2_q <= PIN_IDLE;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
      end
   end
   wire trg_s  = s2_q[12];
   wire pin7_s = s2_q[11];
   wire pin8_s = s2_q[10];
   wire [1:0] sl34_s = s2_q[9:8];
   wire sw_s   = s2_q[7];
   wire cs_n_s = s2_q[6];
   wire rd_n_s = s2_q[5];
   wire wr_n_s = s2_q[4];
   // nibble shares the strobe latency, so it is still valid at the write edge
   wire [3:0] nib_s = s2_q[3:0];

   logic trg_d1_q;
   logic pin7_d1_q;
   logic wr_d1_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trg_d1_q  <= 1'b0;
         pin7_d1_q <= 1'b0;
         wr_d1_q   <= 1'b1;
      end else begin
         trg_d1_q  <= trg_s;
         pin7_d1_q <= pin7_s;
         wr_d1_q   <= wr_n_s;
      end
   end
   wire trg_rise = trg_s & ~trg_d1_q;
   wire wr_rise  = wr_n_s & ~wr_d1_q;

   // ----------------------------------------------------------------
   // channel select register and master clock source
   // ----------------------------------------------------------------
   logic [3:0] chan_reg_q;
   // only a clean write edge counts; read must stay high across it
   wire chan_wr = wr_rise & ~cs_n_s & rd_n_s;
   always_ff @(posedge aclk) begin
      if (!aresetn) chan_reg_q <= 4'h0;
      else if (chan_wr) chan_reg_q <= nib_s;
   end

   wire [3:0] hw_sel  = {sl34_s, pin8_s, pin7_s};
   wire [3:0] cur_sel = sw_s ? chan_reg_q : hw_sel;
   wire use_ext = sw_s & pin8_s;

   logic [1:0] div_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) div_q <= 2'd0;
      else div_q <= div_q + 2'd1;
   end
   wire int_tick = (div_q == 2'(SACC_INT_DIV - 1));
   wire ext_tick = pin7_s & ~pin7_d1_q;
   wire mclk_tick = use_ext ? ext_tick : int_tick;

   // ----------------------------------------------------------------
   // conversion sequencer
   // ----------------------------------------------------------------
   sacc_state_e st_q;
   logic [3:0]  seq_q;
   logic [1:0]  ch_q;
   logic [4:0]  cyc_q;
   logic [DW-1:0] res_q [NCHAN];
   logic [2:0]  nres_q;
   logic [2:0]  ptr_q;
   wire seq_empty = (seq_q == 4'h0);
   wire conv_done = mclk_tick & (cyc_q == 5'(SACC_CONV_CYCLES - 1));
   wire rd_edge;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q   <= SACC_IDLE;
         seq_q  <= 4'h0;
         ch_q   <= 2'd0;
         cyc_q  <= 5'd0;
         nres_q <= 3'd0;
      end else begin
         unique case (st_q)
            SACC_IDLE: begin
               if (trg_rise) begin
                  seq_q  <= cur_sel;
                  nres_q <= 3'd0;
                  st_q   <= SACC_NEXT;
               end
            end
            SACC_NEXT: begin
               cyc_q <= 5'd0;
               if (seq_empty) st_q <= SACC_IDLE;
               else begin
                  st_q <= SACC_CONV;
                  ch_q <= seq_q[0] ? 2'd0 : seq_q[1] ? 2'd1 : seq_q[2] ? 2'd2 : 2'd3;
               end
            end
            SACC_CONV: begin
               if (mclk_tick) cyc_q <= cyc_q + 5'd1;
               if (conv_done) begin
                  res_q[nres_q[1:0]] <= conv_result;
                  nres_q <= nres_q + 3'd1;
                  seq_q[ch_q] <= 1'b0;
                  st_q <= SACC_NEXT;
               end
            end
            default: st_q <= SACC_IDLE;
         endcase
      end
   end

   assign busy = (st_q != SACC_IDLE);
   assign track_hold = {4{busy}};

   // ----------------------------------------------------------------
   // parallel read port
   // ----------------------------------------------------------------
   logic rd_act_q;
   wire rd_act = ~cs_n_s & ~rd_n_s;
   assign rd_edge = rd_act_q & ~rd_act;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_act_q <= 1'b0;
         ptr_q    <= 3'd0;
         data_out <= '0;
      end else begin
         rd_act_q <= rd_act;
         if (trg_rise) ptr_q <= 3'd0;
         else if (rd_edge) ptr_q <= (ptr_q + 3'd1 >= nres_q) ? 3'd0 : ptr_q + 3'd1;
         data_out <= res_q[ptr_q[1:0]];
      end
   end
   // the pads own the tristate; enable is level from the synchronised strobes
   assign data_oe = rd_act;
   assign first_result_flag = (ptr_q == 3'd0);

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   logic [1:0] ist_q;
   logic [1:0] imask_q;
   logic busy_d1_q;
   wire [1:0] ev = {conv_done, busy_d1_q & ~busy};
   wire aw_go;
   wire [31:0] wd = s_axi_wdata;
   wire wr_istat = aw_go & (s_axi_awaddr == SACC_OFS_IRQ_STAT) & s_axi_wstrb[0];
   wire wr_imask = aw_go & (s_axi_awaddr == SACC_OFS_IRQ_MASK) & s_axi_wstrb[0];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ist_q     <= SACC_IRQ_RST;
         imask_q   <= SACC_IRQ_RST;
         busy_d1_q <= 1'b0;
      end else begin
         busy_d1_q <= busy;
         // a new event wins over a clear in the same cycle
         ist_q <= (ist_q & ~(wr_istat ? wd[1:0] : 2'b00)) | ev;
         if (wr_imask) imask_q <= wd[1:0];
      end
   end
   assign irq = |(ist_q & imask_q);

   // ----------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------
   assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_wready  = s_axi_awready;
   assign aw_go = s_axi_awready;
   wire aw_ok = (s_axi_awaddr == SACC_OFS_IRQ_STAT) | (s_axi_awaddr == SACC_OFS_IRQ_MASK);
   assign s_axi_arready = s_axi_arvalid & ~s_axi_rvalid;
   wire [7:0] ra = s_axi_araddr;
   wire ra_res = (ra >= SACC_OFS_RES0) & (ra < SACC_OFS_RES0 + 8'h10);
   wire [1:0] ri = ra[3:2];
   wire ra_ok = (ra == SACC_OFS_CTRL) | (ra == SACC_OFS_STATUS) | (ra == SACC_OFS_IRQ_STAT)
                | (ra == SACC_OFS_IRQ_MASK) | ra_res;
   wire [31:0] rmux =
      (ra == SACC_OFS_CTRL)     ? {28'h0, chan_reg_q} :
      (ra == SACC_OFS_STATUS)   ? {22'h0, nres_q, ptr_q, use_ext, sw_s, first_result_flag, busy} :
      (ra == SACC_OFS_IRQ_STAT) ? {30'h0, ist_q} :
      (ra == SACC_OFS_IRQ_MASK) ? {30'h0, imask_q} :
      ra_res                    ? {{(32-DW){1'b0}}, res_q[ri]} : 32'h0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= SACC_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= SACC_RESP_OKAY;
         s_axi_rdata  <= 32'h0;
      end else begin
         if (aw_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= aw_ok ? SACC_RESP_OKAY : SACC_RESP_SLVERR;
         end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rmux;
            s_axi_rresp  <= ra_ok ? SACC_RESP_OKAY : SACC_RESP_SLVERR;
         end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_busy_on_trig: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_q == SACC_IDLE) && trg_rise |=> busy) else $error("busy not raised");
   a_first_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      trg_rise |=> first_result_flag) else $error("first flag mismatch");
   a_hold_all: assert property (@(posedge aclk) disable iff (!aresetn)
      busy |-> track_hold == 4'hf) else $error("track/holds not together");
   a_sel_capture: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_q == SACC_IDLE) && trg_rise |=> seq_q == $past(cur_sel)) else $error("sel not latched");
   a_oe_strobes: assert property (@(posedge aclk) disable iff (!aresetn)
      data_oe |-> !cs_n_s && !rd_n_s) else $error("data driven without strobes");
   a_oe_release: assert property (@(posedge aclk) disable iff (!aresetn)
      cs_n_s || rd_n_s |-> !data_oe) else $error("bus not released");
   a_chan_write: assert property (@(posedge aclk) disable iff (!aresetn)
      chan_wr |=> chan_reg_q == $past(nib_s)) else $error("channel write lost");
   a_no_sel_write: assert property (@(posedge aclk) disable iff (!aresetn)
      cs_n_s |=> $stable(chan_reg_q)) else $error("write while deselected");
   a_conv_len: assert property (@(posedge aclk) disable iff (!aresetn)
      conv_done |-> cyc_q == 5'd15) else $error("conversion length wrong");
   a_int_clock: assert property (@(posedge aclk) disable iff (!aresetn)
      !use_ext |-> mclk_tick == int_tick) else $error("internal clock not used");
endmodule

// [tb/sacc_host_model.sv]
// host model: parallel strobes, trigger pin and external clock pin
// assumes the dut syncs every pin through two flops on clk
`timescale 1ns/1ps
module sacc_host_model (
   input  wire logic        clk,
   input  wire logic        ext_run,
   input  wire logic        sel1,
   input  wire logic [13:0] dq,
   input  wire logic        oe,
   output logic             trig,
   output logic             ckpin,
   output logic             cs_n,
   output logic             rd_n,
   output logic             wr_n,
   output logic [3:0]       nib
);
   logic ck;
   int   n;
   initial begin
      ck = 1'b0;
      n = 0;
      trig = 1'b0;
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      nib = 4'ha;
   end
   // clock stands still low outside runs; 50/50 duty, period 10 clk
   always @(posedge clk) begin
      n <= (ext_run && n < 4) ? n + 1 : 0;
      ck <= ext_run ? (n == 4 ? ~ck : ck) : 1'b0;
   end
   assign ckpin = ext_run ? ck : sel1;
   task automatic trg(input logic v);
      trig <= v;
   endtask
   task automatic wr(input logic sel, input logic [3:0] d);
      cs_n <= ~sel;
      nib <= d;
      repeat (2) @(posedge clk);
      wr_n <= 1'b0;
      repeat (4) @(posedge clk);
      wr_n <= 1'b1;
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      nib <= ~d; // released bus shows no stale value
      repeat (3) @(posedge clk);
   endtask
   task automatic rd(input logic sel, output logic [13:0] d, output logic e);
      cs_n <= ~sel;
      rd_n <= 1'b0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      d = dq;
      e = oe;
      @(posedge clk);
      rd_n <= 1'b1;
      cs_n <= 1'b1;
      repeat (5) @(posedge clk);
   endtask
endmodule

// [tb/sacc_top_tb_top.sv]
// self-checking bench for the conversion control block
// assumes sacc_pkg is compiled first; host model drives the strobe pins
`timescale 1ns/1ps
module sacc_top_tb_top;
   import sacc_pkg::*;
   localparam logic [13:0] RES = 14'h2a5c;
   logic aclk, aresetn, sw, srcpin, sel1, ext_run, trig, ckpin, cs_n, rd_n, wr_n;
   logic busy, flag, oe, irq, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
   logic [1:0] hi, bresp, rresp, wresp;
   logic [3:0] nib, th;
   logic [13:0] dq, d;
   logic [7:0] awa, ara;
   logic [31:0] wd, rd, v;
   logic e;
   int failures = 0;
   int samples_checked = 0;
   sacc_top dut (.aclk(aclk), .aresetn(aresetn), .sample_trigger(trig),
      .ext_clock_or_chan_one_select(ckpin), .clock_source_or_chan_two_select(srcpin),
      .chan_hi_select(hi), .sw_control(sw), .dev_select_n(cs_n), .read_n(rd_n),
      .write_n(wr_n), .low_data_nibble(nib), .conv_result(RES), .data_out(dq),
      .data_oe(oe), .busy(busy), .first_result_flag(flag), .track_hold(th), .irq(irq),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(wresp),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rr));
   sacc_host_model host (.clk(aclk), .ext_run(ext_run), .sel1(sel1), .dq(dq), .oe(oe),
      .trig(trig), .ckpin(ckpin), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .nib(nib));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic chk_rng(input string nm, input int x, input int g, input int tol);
      samples_checked++;
      if (g < x - tol || g > x + tol) begin
         failures++;
         $display("unexpected %s: expected %0d seen %0d", nm, x, g);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] x);
      awa <= a;
      wd <= x;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do @(posedge aclk); while (awr !== 1'b1);
      chk("wready", 1, wr);
      awv <= 1'b0;
      wv <= 1'b0;
      do @(posedge aclk); while (bv !== 1'b1);
      br <= 1'b0;
      chk("bresp", SACC_RESP_OKAY, wresp);
      @(posedge aclk);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] x, output logic [1:0] r);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do @(posedge aclk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge aclk); while (rv !== 1'b1);
      x = rd;
      r = rresp;
      rr <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic seq(input int n, input int per);
      int k;
      host.trg(1'b1);
      k = 0;
      do begin
         @(posedge aclk);
         k++;
      end while (busy !== 1'b1 && k < 10);
      chk("busy_rise", 1, k < 10);
      chk("hold_all", 4'hf, th);
      hi <= ~hi;
      host.trg(1'b0);
      k = 0;
      while (busy === 1'b1 && k < 5000) begin
         @(posedge aclk);
         k++;
      end
      chk_rng("busy_len", n * (SACC_CONV_CYCLES * per + 1), k, per + 3);
      axr(SACC_OFS_STATUS, v, bresp);
      chk("nres", n, v[9:7]);
      chk("flag_start", 1, flag);
      for (int i = 0; i < n; i++) begin
         host.rd(1'b1, d, e);
         chk("data", RES, d);
         chk("oe", 1, e);
         chk("flag", i == n - 1, flag);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   initial begin
      #(60000 * 8);
      failures++;
      end_of_test();
   end
   initial begin
      {aresetn, sw, srcpin, sel1, ext_run, awv, wv, br, arv, rr} = '0;
      {hi, awa, ara, wd} = '0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("rst_busy", 0, busy);
      chk("rst_oe", 0, oe);
      chk("rst_irq", 0, irq);
      axr(SACC_OFS_CTRL, v, bresp);
      chk("ctrl_rst", SACC_CTRL_RST, v);
      axr(8'h40, v, bresp);
      chk("unmapped", SACC_RESP_SLVERR, bresp);
      $display("test reset done");
      sel1 <= 1'b1;
      hi <= 2'b10;
      seq(2, SACC_INT_DIV);
      sel1 <= 1'b0;
      srcpin <= 1'b1;
      seq(2, SACC_INT_DIV);
      srcpin <= 1'b0;
      hi <= 2'b00;
      seq(0, SACC_INT_DIV);
      $display("test hardware select done");
      host.rd(1'b0, d, e);
      chk("oe_desel", 0, e);
      sw <= 1'b1;
      host.wr(1'b1, 4'b1001);
      host.wr(1'b0, 4'b0110);
      axr(SACC_OFS_CTRL, v, bresp);
      chk("chan_reg", 32'h9, v);
      seq(2, SACC_INT_DIV);
      axr(SACC_OFS_RES0, v, bresp);
      chk("res0", RES, v);
      srcpin <= 1'b1;
      ext_run <= 1'b1;
      seq(2, 10);
      ext_run <= 1'b0;
      $display("test software select done");
      axr(SACC_OFS_IRQ_STAT, v, bresp);
      chk("irq_stat", 32'h3, v);
      // a set mask bit lets its status bit through; mask is clear after reset
      chk("irq_mask", 0, irq);
      axw(SACC_OFS_IRQ_MASK, 32'h3);
      chk("irq_unmask", 1, irq);
      axw(SACC_OFS_IRQ_STAT, 32'h1);
      chk("irq_set", 1, irq);
      axw(SACC_OFS_IRQ_STAT, 32'h2);
      chk("irq_clr", 0, irq);
      axr(SACC_OFS_IRQ_STAT, v, bresp);
      chk("irq_stat_clr", 32'h0, v);
      $display("test interrupt done");
      end_of_test();
   end
endmodule
